// File: logic/tasc_ctrl.sv
/*
 * Analog-settings controller: takes swing, tap, equalizer and DC gain codes
 * from fabric logic, writes them into per-channel control registers and
 * reads them back.
 * A write copies the presented codes at the strobe, waits out the fixed
 * transfer time and then commits them to the selected channel registers.
 * A read waits the same time and copies the channel registers into the
 * readback slots, raising data_valid once they are settled.
 * A write that carries an illegal DC gain code is refused as a whole and
 * answered by a two-cycle error pulse instead of busy.
 * The channel selection is frozen at the strobe, so a change of the
 * addressing inputs during a transfer has no effect on it.
 * Assumes all inputs come from logic on the same clock, that the strobes
 * are one-cycle pulses and that clk_en low may freeze a transfer midway.
 */
`timescale 1ns/10ps
// Function
// - Swing input is 3 bits per channel, one shared field when addressed or shared.
// - First-generation swing codes map 200 to 1200 mV, code 3 is 700 mV.
// - Second-generation swing codes 0-5 give 200-1200 mV, 6 is 700, 7 is 900.
// - Second-generation swing readback returns the code last written to that channel.
// - Each tap input is 5 bits per channel, one shared field when addressed or shared.
// - Pre-tap code is written into the pre-emphasis register, both polarities.
// - Pre-tap codes 0 and 16 mean zero, 1-15 negative, 17-31 positive.
// - Second post-tap uses the same coding and goes to the emphasis register.
// - First post-tap code is written to the addressed channel's post-tap register.
// - Second-generation boost code is written to the pre-emphasis control register.
// - Second-generation cut code is written to the de-emphasis control register.
// - Equalization input is 4 bits per channel and written to the receive setting.
// - DC gain codes 0-4 give 0-12 dB; codes 5-7 are refused.
// - Each readback returns the value previously written, one slot per channel.
// - One-cycle read strobe starts a read; readback valid only while data_valid high.
// - Busy stays high while a read or write transaction runs.
module tasc_ctrl
    import tasc_pkg::*;
(
    // Clock, reset and freeze
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // Strobes and mode from fabric
    input wire logic write_all,
    input wire logic read_strobe,
    input wire logic [2:0] mode_sel,
    // Channel addressing
    input wire logic shared_ctrl,
    input wire logic logical_addr_en,
    input wire logic [CH_AW-1:0] logical_channel_address,
    // Presented codes
    input wire tasc_setting_t setting_in [NUM_CH],
    // Status
    output logic busy,
    output logic data_valid,
    output logic error,
    // Readback slots, channel registers and their decoded levels
    output tasc_setting_t readback [NUM_CH],
    output tasc_setting_t chan_setting [NUM_CH],
    output tasc_drive_t chan_drive [NUM_CH]
);

    // Sequencer state and its next values
    tasc_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic op_wr_q, op_wr_d;

    // Status flags
    logic busy_q, busy_d;
    logic dv_q, dv_d;
    logic err_q, err_d;

    // Channels taken by the transfer in hand, and channels with a bad gain
    logic [NUM_CH-1:0] sel_now;
    logic [NUM_CH-1:0] sel_q, sel_d;
    logic [NUM_CH-1:0] bad_now;

    // Strobe decode
    logic start_wr, start_rd, start, commit;

    // Captured codes and readback slots, one entry per channel
    tasc_setting_t src [NUM_CH];
    tasc_setting_t data_q [NUM_CH];
    tasc_setting_t data_d [NUM_CH];
    tasc_setting_t rb_q [NUM_CH];
    tasc_setting_t rb_d [NUM_CH];

    // Strobes count only in idle and only in analog-controls mode
    assign start_wr = (state_q == ST_IDLE) && write_all && (mode_sel == MODE_ANALOG);
    assign start_rd = (state_q == ST_IDLE) && !write_all && read_strobe
        && (mode_sel == MODE_ANALOG);
    assign start = start_wr || start_rd;
    // Commit marks the last cycle of a transfer, read or write
    assign commit = (state_q == ST_XFER) && (cnt_q == 3'h0);

    // Per-channel source select, capture, commit and readback
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        // Addressed or shared control narrows every input to slot 0
        assign src[ch] = (shared_ctrl || logical_addr_en) ? setting_in[0]
            : setting_in[ch];
        // Every channel, or only the addressed one, takes part in the transfer
        assign sel_now[ch] = shared_ctrl || !logical_addr_en
            || (logical_channel_address == CH_AW'(ch));
        assign bad_now[ch] = sel_now[ch] && (src[ch].rx_dcgain > DCGAIN_MAX);

        // Inputs are captured at the strobe so fabric may change them later
        always_comb begin
            data_d[ch] = start_wr ? src[ch] : data_q[ch];
            rb_d[ch] = rb_q[ch];
            if (commit && !op_wr_q && sel_q[ch]) begin
                rb_d[ch] = chan_setting[ch];
            end
        end

        always_ff @(posedge clock) begin
            if (!reset_n) begin
                data_q[ch] <= tasc_setting_t'(SETTING_RST);
                rb_q[ch] <= tasc_setting_t'(SETTING_RST);
            end else if (clk_en) begin
                data_q[ch] <= data_d[ch];
                rb_q[ch] <= rb_d[ch];
            end
        end

        // Write enable also carries clk_en so a frozen cycle cannot commit
        tasc_chan_reg u_chan (
            .clock(clock),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .wr_en(commit && op_wr_q && sel_q[ch] && clk_en),
            .wr_data(data_q[ch]),
            .setting_q(chan_setting[ch]),
            .drive_q(chan_drive[ch])
        );

        // Readback slots drive the output ports directly
        assign readback[ch] = rb_q[ch];
    end

    // Transaction sequencer; an illegal gain refuses the whole write
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        op_wr_d = op_wr_q;
        sel_d = sel_q;
        busy_d = busy_q;
        dv_d = dv_q;
        err_d = err_q;
        case (state_q)
            ST_IDLE: begin
                // A refused write leaves op and selection untouched, so nothing commits
                if (start_wr && (bad_now != '0)) begin
                    state_d = ST_ERR;
                    cnt_d = 3'(ERR_CYCLES - 1);
                    err_d = 1'b1;
                    dv_d = 1'b0;
                end else if (start) begin
                    state_d = ST_XFER;
                    cnt_d = 3'(XFER_CYCLES - 1);
                    op_wr_d = start_wr;
                    sel_d = sel_now;
                    busy_d = 1'b1;
                    dv_d = 1'b0;
                end
            end
            ST_XFER: begin
                // The counter runs down to zero; the commit fires on its last cycle
                if (cnt_q == 3'h0) begin
                    state_d = ST_IDLE;
                    busy_d = 1'b0;
                    dv_d = !op_wr_q;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_ERR: begin
                // Error holds for ERR_CYCLES and then lets strobes in again
                if (cnt_q == 3'h0) begin
                    state_d = ST_IDLE;
                    err_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            default: begin
                // Unreachable codes fall back to idle with all flags low
                state_d = ST_IDLE;
                busy_d = 1'b0;
                dv_d = 1'b0;
                err_d = 1'b0;
            end
        endcase
    end

    // Sequencer registers; a low clk_en holds every count and flag
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            op_wr_q <= 1'b0;
            sel_q <= '0;
            busy_q <= 1'b0;
            dv_q <= 1'b0;
            err_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            op_wr_q <= op_wr_d;
            sel_q <= sel_d;
            busy_q <= busy_d;
            dv_q <= dv_d;
            err_q <= err_d;
        end
    end

    // Status outputs come straight from their registers
    assign busy = busy_q;
    assign data_valid = dv_q;
    assign error = err_q;

endmodule

// File: logic/tasc_pkg.sv
/*
 * Shared constants and types of the transceiver analog-setting controller.
 * Assumes one reconfiguration clock at 40 MHz and a fixed channel count.
 */
package tasc_pkg;

    localparam int NUM_CH = 4;
    localparam int CH_AW = 2;

    // Clock and transaction timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int XFER_TIME_NS = 100;
    localparam int XFER_CYCLES = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERR_CYCLES = 2;

    // Mode select code for analog-controls reconfiguration
    localparam logic [2:0] MODE_ANALOG = 3'h0;

    // Highest legal equalizer DC gain code and its step in dB
    localparam logic [2:0] DCGAIN_MAX = 3'h4;
    localparam logic [3:0] DCGAIN_STEP_DB = 4'h3;

    // Tap weight: zero magnitude, and the bit flipped to turn code into weight
    localparam logic [3:0] TAP_ZERO_MAG = 4'h0;
    localparam logic [4:0] TAP_BIAS = 5'h10;

    // Reset value of every stored setting
    localparam logic [37:0] SETTING_RST = 38'h0;

    // Settings of one channel, as presented and as stored
    typedef struct packed {
        logic [2:0] vod;
        logic [2:0] vod_gen2;
        logic [4:0] tx_pretap_weight;
        logic [4:0] tx_posttap1_weight;
        logic [4:0] tx_posttap1_boost_gen2;
        logic [4:0] tx_posttap1_cut_gen2;
        logic [4:0] tx_posttap2_weight;
        logic [3:0] rx_eq;
        logic [2:0] rx_dcgain;
    } tasc_setting_t;

    // Decoded analog levels handed to the channel's buffers
    typedef struct packed {
        logic [10:0] vod_mv;
        logic [10:0] vod_gen2_mv;
        logic signed [4:0] pretap_w;
        logic signed [4:0] posttap2_w;
        logic [3:0] dcgain_db;
    } tasc_drive_t;

    // Reset value of the decoded levels: code 0 swings 200 mV, no taps, no gain
    localparam tasc_drive_t DRIVE_RST = '{vod_mv: 11'd200, vod_gen2_mv: 11'd200, default: '0};

    // Controller states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_ERR = 3'b100
    } tasc_state_t;

endpackage

// File: logic/tasc_chan_reg.sv
/*
 * One channel's analog control register and its decoded drive levels.
 * Assumes the controller pulses wr_en for one cycle with wr_data stable.
 */
`timescale 1ns/10ps
module tasc_chan_reg
    import tasc_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire tasc_setting_t wr_data,
    output tasc_setting_t setting_q,
    output tasc_drive_t drive_q
);

    tasc_setting_t setting_d;
    tasc_drive_t drive_d;

    // First-generation swing in mV, monotonic over the code
    function automatic logic [10:0] vod_gen1_mv(input logic [2:0] c);
        case (c)
            3'h0: vod_gen1_mv = 11'd200;
            3'h1: vod_gen1_mv = 11'd400;
            3'h2: vod_gen1_mv = 11'd600;
            3'h3: vod_gen1_mv = 11'd700;
            3'h4: vod_gen1_mv = 11'd800;
            3'h5: vod_gen1_mv = 11'd900;
            3'h6: vod_gen1_mv = 11'd1000;
            default: vod_gen1_mv = 11'd1200;
        endcase
    endfunction

    // Second-generation swing in mV; codes 6 and 7 fill in the gaps
    function automatic logic [10:0] vod_gen2_mv(input logic [2:0] c);
        case (c)
            3'h0: vod_gen2_mv = 11'd200;
            3'h1: vod_gen2_mv = 11'd400;
            3'h2: vod_gen2_mv = 11'd600;
            3'h3: vod_gen2_mv = 11'd800;
            3'h4: vod_gen2_mv = 11'd1000;
            3'h5: vod_gen2_mv = 11'd1200;
            3'h6: vod_gen2_mv = 11'd700;
            default: vod_gen2_mv = 11'd900;
        endcase
    endfunction

    // Codes 0 and 16 are zero; flipping bit 4 gives the signed weight
    function automatic logic signed [4:0] tap_w(input logic [4:0] c);
        if (c[3:0] == TAP_ZERO_MAG) begin
            tap_w = 5'sh0;
        end else begin
            tap_w = $signed(c ^ TAP_BIAS);
        end
    endfunction

    // Register write and decode of the written value
    always_comb begin
        setting_d = wr_en ? wr_data : setting_q;
        drive_d.vod_mv = vod_gen1_mv(setting_d.vod);
        drive_d.vod_gen2_mv = vod_gen2_mv(setting_d.vod_gen2);
        drive_d.pretap_w = tap_w(setting_d.tx_pretap_weight);
        drive_d.posttap2_w = tap_w(setting_d.tx_posttap2_weight);
        drive_d.dcgain_db = 4'(setting_d.rx_dcgain * DCGAIN_STEP_DB);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            setting_q <= tasc_setting_t'(SETTING_RST);
            drive_q <= DRIVE_RST;
        end else if (clk_en) begin
            setting_q <= setting_d;
            drive_q <= drive_d;
        end
    end

endmodule

// File: verification/tasc_checker.sv
/*
 * Port assertions for tasc_ctrl: transfer timing, refusals and holds.
 * Assumes it is bound into tasc_ctrl by port name.
 */
`timescale 1ns/10ps
module tasc_checker
    import tasc_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic write_all,
    input wire logic read_strobe,
    input wire logic [2:0] mode_sel,
    input wire logic shared_ctrl,
    input wire logic logical_addr_en,
    input wire tasc_setting_t setting_in [NUM_CH],
    input wire logic busy,
    input wire logic data_valid,
    input wire logic error,
    input wire tasc_setting_t readback [NUM_CH],
    input wire tasc_setting_t chan_setting [NUM_CH]
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic idle, stb, bad, wr_ok, wr_bad, rd_ok;
    logic [NUM_CH*$bits(tasc_setting_t)-1:0] rb_all, cs_all;
    // Accept terms; a per-channel write is refused if any slot has a bad gain
    always_comb begin
        idle = clk_en && !busy && !error && mode_sel == MODE_ANALOG;
        stb = write_all || read_strobe;
        bad = setting_in[0].rx_dcgain > DCGAIN_MAX;
        for (int c = 1; c < NUM_CH; c++)
            bad |= !shared_ctrl && !logical_addr_en && setting_in[c].rx_dcgain > DCGAIN_MAX;
        wr_ok = idle && write_all && !bad;
        wr_bad = idle && write_all && bad;
        rd_ok = idle && read_strobe && !write_all;
        rb_all = {>>{readback}};
        cs_all = {>>{chan_setting}};
    end
    a_busy_span: assert property (wr_ok || rd_ok |=> busy [*4] ##1 !busy)
        else $error("busy span wrong");
    a_error_pulse: assert property (wr_bad |=> (error && !busy) [*2] ##1 !error)
        else $error("error pulse wrong");
    a_read_valid: assert property (rd_ok |=> !data_valid ##4 data_valid)
        else $error("data valid timing wrong");
    a_valid_hold: assert property (data_valid && !(idle && stb) |=> data_valid)
        else $error("data valid dropped");
    a_rdbk_hold: assert property (!$stable(rb_all) |-> $fell(busy) && data_valid)
        else $error("readback moved outside a read");
    a_set_hold: assert property (!$stable(cs_all) |-> $fell(busy) && !data_valid)
        else $error("setting moved outside a write");
    a_shared_fan: assert property (wr_ok && shared_ctrl |->
        ##5 chan_setting[NUM_CH-1] == $past(setting_in[0], 5))
        else $error("shared write missed a channel");
    a_mode_drop: assert property (stb && !busy && !error && mode_sel != 3'h0 |=> !busy)
        else $error("strobe taken in wrong mode");
endmodule

// File: verification/tasc_fabric.sv
/*
 * Fabric-side strobe source for tasc_ctrl.
 * Assumes the bench raises a request flag for one cycle per transfer.
 */
`timescale 1ns/10ps
module tasc_fabric (
    input wire logic clock,
    input wire logic wr_req,
    input wire logic rd_req,
    output logic write_all,
    output logic read_strobe
);
    // Registered, so each strobe lasts one clock and moves just after the edge
    always_ff @(posedge clock) begin
        write_all <= wr_req;
        read_strobe <= rd_req;
    end
endmodule

// File: verification/tb.sv
/*
 * Bench for tasc_ctrl: codes, readback, refusals, shared and logical modes.
 * Assumes the four-channel package and strobes from tasc_fabric.
 */
`timescale 1ns/10ps
module tb;
    import tasc_pkg::*;
    logic clock = 0, reset_n = 0, clk_en = 1, wr_req = 0, rd_req = 0;
    logic shared_ctrl = 0, logical_addr_en = 0, write_all, read_strobe, busy, data_valid, error;
    logic [2:0] mode_sel = 3'h0;
    logic [CH_AW-1:0] logical_channel_address = 2'h2;
    tasc_setting_t setting_in [NUM_CH] = '{default: '0};
    tasc_setting_t readback [NUM_CH], chan_setting [NUM_CH];
    tasc_drive_t chan_drive [NUM_CH];
    int miscompares = 0, checks_done = 0;
    int n_busy = 0, n_err = 0;
    int vod_tab [8] = '{200, 400, 600, 700, 800, 900, 1000, 1200};
    int g2_tab [8] = '{200, 400, 600, 800, 1000, 1200, 700, 900};
    logic [4:0] tap [8] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h11, 5'h1f, 5'h08, 5'h18};
    // 40 MHz clock
    always #12.5 clock = ~clock;
    tasc_fabric fab (.*);
    tasc_ctrl dut (.*);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Distinct legal settings; gain stays within 0 to 4
    function automatic tasc_setting_t mk(input int i);
        return '{3'(i), 3'(i), tap[i], 5'(i + 3), 5'(i + 9), 5'(i + 20), tap[7 - i], 4'(i + 5),
            3'(i % 5)};
    endfunction
    // Codes 0 and 16 both give no emphasis
    function automatic int tw(input logic [4:0] code);
        return (code == 5'h0) ? 0 : int'(code) - 16;
    endfunction
    // One strobe, then a fixed wait; busy and error cycles are counted meanwhile
    task automatic go(input logic wr);
        n_busy = 0;
        n_err = 0;
        @(posedge clock);
        wr_req <= wr;
        rd_req <= !wr;
        @(posedge clock);
        wr_req <= 1'h0;
        rd_req <= 1'h0;
        repeat (6) begin
            @(posedge clock);
            #1;
            if (busy !== 1'b0) n_busy++;
            if (error !== 1'b0) n_err++;
        end
    endtask
    // All eight swing and tap codes over two writes, each read back
    task automatic t_codes;
        for (int w = 0; w < 8; w += 4) begin
            @(posedge clock);
            for (int c = 0; c < NUM_CH; c++)
                setting_in[c] <= mk(w + c);
            go(1);
            chk(n_busy, 4);
            for (int c = 0; c < NUM_CH; c++) begin
                chk(chan_setting[c], mk(w + c));
                chk(chan_drive[c].vod_mv, vod_tab[w + c]);
                chk(chan_drive[c].vod_gen2_mv, g2_tab[w + c]);
                chk(chan_drive[c].pretap_w, tw(tap[w + c]));
                chk(chan_drive[c].posttap2_w, tw(tap[7 - w - c]));
                chk(chan_drive[c].dcgain_db, (w + c) % 5 * 3);
            end
            go(0);
            chk(n_busy, 4);
            chk(data_valid, 1'h1);
            for (int c = 0; c < NUM_CH; c++)
                chk(readback[c], mk(w + c));
        end
    endtask
    // A read strobe that lands while a write is busy is dropped
    task automatic t_busy_drop;
        @(posedge clock);
        wr_req <= 1'h1;
        @(posedge clock);
        wr_req <= 1'h0;
        rd_req <= 1'h1;
        @(posedge clock);
        rd_req <= 1'h0;
        repeat (6) @(posedge clock);
        #1;
        chk(data_valid, 1'h0);
    endtask
    // Bad gain on one channel refuses the whole write; so does a foreign mode
    task automatic t_refuse;
        @(posedge clock);
        setting_in[2].rx_dcgain <= 3'h5;
        setting_in[1] <= mk(0);
        go(1);
        chk(n_err, 2);
        chk(n_busy, 0);
        chk(chan_setting[1], mk(5));
        @(posedge clock);
        mode_sel <= 3'h3;
        setting_in[2] <= mk(0);
        go(1);
        chk(chan_setting[2], mk(6));
        chk(n_busy + n_err, 0);
        @(posedge clock);
        mode_sel <= 3'h0;
    endtask
    // Shared control fans slot 0 out; logical mode touches one channel
    task automatic t_modes;
        @(posedge clock);
        shared_ctrl <= 1'h1;
        setting_in[0] <= mk(3);
        go(1);
        for (int c = 0; c < NUM_CH; c++)
            chk(chan_setting[c], mk(3));
        @(posedge clock);
        shared_ctrl <= 1'h0;
        logical_addr_en <= 1'h1;
        setting_in[0] <= mk(1);
        go(1);
        chk(chan_setting[2], mk(1));
        chk(chan_setting[1], mk(3));
        go(0);
        chk(readback[2], mk(1));
        chk(readback[1], mk(5));
    endtask
    // Zeroed taps for a rate switch, a strobe while frozen, then a mid-run reset
    task automatic t_freeze;
        tasc_setting_t s;
        s = mk(1);
        s.tx_pretap_weight = 5'h00;
        s.tx_posttap2_weight = 5'h00;
        @(posedge clock);
        setting_in[0] <= s;
        go(1);
        chk(chan_drive[2].pretap_w, 0);
        chk(chan_drive[2].posttap2_w, 0);
        @(posedge clock);
        clk_en <= 1'h0;
        setting_in[0] <= mk(7);
        go(1);
        chk(n_busy, 0);
        @(posedge clock);
        clk_en <= 1'h1;
        #1;
        chk(chan_setting[2].tx_posttap1_weight, 5'h04);
        // Three reset edges leave the checker's sampled history settled at release
        @(posedge clock);
        reset_n <= 1'h0;
        repeat (3) @(posedge clock);
        reset_n <= 1'h1;
        #1;
        chk(readback[2], SETTING_RST);
        chk(chan_drive[2].vod_gen2_mv, 200);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'h1;
        #1;
        chk(busy, 1'h0);
        chk(chan_drive[0].vod_mv, 200);
        t_codes();
        t_busy_drop();
        t_refuse();
        t_modes();
        t_freeze();
        test_done();
    end
    // Watchdog; the sequence needs about 130 cycles
    initial begin
        #(CLK_PERIOD_NS * 2000);
        miscompares++;
        test_done();
    end
endmodule
bind tasc_ctrl tasc_checker chk_i (.*);
